// ---- rtl/dos_pkg.sv ----
// shared constants and state types for the dc offset servo block
package dos_pkg;

    // clock and timing
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned CLK_FREQ_KHZ  = 1000000 / CLK_PERIOD_NS;
    localparam int unsigned TICK_TIME_MS  = 256;
    localparam int unsigned TICK_CYCLES   = TICK_TIME_MS * CLK_FREQ_KHZ;
    localparam int unsigned TICK_W        = 23;
    localparam int unsigned MEAS_TIME_NS  = 640;
    localparam int unsigned MEAS_CYCLES   = (MEAS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned MEAS_W        = 5;
    localparam int unsigned TMR_W         = 16;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_ENABLE      = 8'h43;
    localparam logic [7:0] IDX_TRIGGER     = 8'h44;
    localparam logic [7:0] IDX_INTERVAL    = 8'h45;
    localparam logic [7:0] IDX_COUNT_LINE  = 8'h47;
    localparam logic [7:0] IDX_COUNT_HP    = 8'h48;
    localparam logic [7:0] IDX_VALUE_LR    = 8'h49;
    localparam logic [7:0] IDX_VALUE_LL    = 8'h4a;
    localparam logic [7:0] IDX_VALUE_HR    = 8'h4b;
    localparam logic [7:0] IDX_VALUE_HL    = 8'h4c;
    localparam logic [7:0] IDX_IRQ_STATUS  = 8'h50;
    localparam logic [7:0] IDX_IRQ_MASK    = 8'h51;

    // field positions
    localparam int unsigned SINGLE_LSB      = 12;
    localparam int unsigned SERIES_LSB      = 8;
    localparam int unsigned LINE_PERIOD_LSB = 8;
    localparam int unsigned HP_PERIOD_LSB   = 0;
    localparam int unsigned IRQ_SERIES_LSB  = 4;

    // reset values and offset range limits
    localparam logic [3:0] RST_PERIOD = 4'ha;
    localparam logic [6:0] RST_COUNT  = 7'h2a;
    localparam logic [7:0] VALUE_MAX  = 8'h7f;
    localparam logic [7:0] VALUE_MIN  = 8'h80;

    typedef enum logic [0:0] {
        DOS_IDLE,
        DOS_MEAS
    } dos_phase_t;

    typedef struct packed {
        dos_phase_t        phase;
        logic [MEAS_W-1:0] meas_cnt;
        logic [6:0]        series_left;
        logic              single;
        logic              series;
        logic [7:0]        value;
    } dos_chan_t;

    typedef struct packed {
        logic [3:0]        enable;
        logic [3:0]        line_period;
        logic [3:0]        hp_period;
        logic [6:0]        line_count;
        logic [6:0]        hp_count;
        logic [7:0]        irq_status;
        logic [7:0]        irq_mask;
        logic [TICK_W-1:0] tick_cnt;
        logic              tick;
        logic              restart;
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
        logic              irq;
        dos_chan_t [3:0]   chan;
    } dos_state_t;

    localparam dos_state_t DOS_STATE_RST = '{
        line_period: RST_PERIOD,
        hp_period:   RST_PERIOD,
        line_count:  RST_COUNT,
        hp_count:    RST_COUNT,
        default:     '0
    };

    typedef struct packed {
        logic [TMR_W-1:0] cnt;
        logic             fire;
    } dos_timer_t;

endpackage : dos_pkg

// ---- rtl/dos_pair_timer.sv ----
// periodic update timer for one channel pair, counted in fixed ticks
`timescale 1ns/1ps
`default_nettype none
module dos_pair_timer
    import dos_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       tick,
    input  wire logic [3:0] period,
    input  wire logic       restart,
    output var  logic       fire
);

    dos_timer_t       t_r;
    dos_timer_t       t_nxt;
    logic [TMR_W-1:0] last;

    always_comb begin
        t_nxt      = t_r;
        t_nxt.fire = 1'b0;
        last = (TMR_W'(1) << period) - TMR_W'(1);
        if (restart || period == 4'h0) begin
            t_nxt.cnt = '0;
        end else if (tick) begin
            if (t_r.cnt == last) begin
                t_nxt.cnt  = '0;
                t_nxt.fire = 1'b1;
            end else begin
                t_nxt.cnt = t_r.cnt + TMR_W'(1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t_r <= '0;
        end else begin
            t_r <= t_nxt;
        end
    end

    assign fire = t_r.fire;

endmodule : dos_pair_timer
`default_nettype wire

// ---- rtl/dos_servo.sv ----
// active-mode dc offset servo control with apb register access
//
// What this block does
// - a channel is corrected only while its servo enable bit is set (1 hp right, 0 hp left, 3 line right, 2 line left).
// - writing one to a one-shot trigger bit starts one measurement and adjustment on that channel.
// - each correction moves the channel's stored offset by at most one step of a quarter millivolt.
// - one-shot triggers sit at bits 15:12 and read as one while their correction runs.
// - multi-correction triggers at bits 11:8 start a run of corrections and read as one while it runs.
// - a run performs count+1 updates, the 7-bit count held per pair and reset to 0x2a.
// - a 4-bit interval field gives 0.256 s times two to its value, zero turns it off, reset is 0xa.
// - a non-zero interval schedules one correction on its pair each interval, line at 11:8, headphone at 3:0.
// - each channel's present offset reads back as an 8-bit two's complement value.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module dos_servo
    import dos_pkg::*;
#(
    parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [11:0]     paddr,
    input  wire logic [31:0]     pwdata,
    input  wire logic [3:0]      pstrb,
    output var  logic [31:0]     prdata,
    output var  logic            pready,
    output var  logic            pslverr,
    input  wire logic [3:0]      offset_high,
    output var  logic [3:0][7:0] channel_offset_value,
    output var  logic            irq
);

    dos_state_t  s_r;
    dos_state_t  s_nxt;
    logic        hp_fire;
    logic        line_fire;
    logic        setup;
    logic        wr;
    logic        mapped;
    logic [7:0]  idx;
    logic [15:0] wmask;
    logic [15:0] wd;
    logic [15:0] old16;
    logic [15:0] new16;
    logic [31:0] rdata;
    logic [3:0]  single_vec;
    logic [3:0]  series_vec;
    logic [3:0]  trig_single;
    logic [3:0]  trig_series;
    logic [3:0]  fire_vec;
    logic [7:0]  events;
    logic [7:0]  w1c;

    dos_pair_timer u_hp_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (s_r.tick),
        .period  (s_r.hp_period),
        .restart (s_r.restart),
        .fire    (hp_fire)
    );

    dos_pair_timer u_line_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (s_r.tick),
        .period  (s_r.line_period),
        .restart (s_r.restart),
        .fire    (line_fire)
    );

    always_comb begin
        s_nxt         = s_r;
        s_nxt.pready  = 1'b0;
        s_nxt.pslverr = 1'b0;
        s_nxt.tick    = 1'b0;
        s_nxt.restart = 1'b0;

        idx    = paddr[9:2];
        setup  = psel && !penable;
        // the write lands only at the edge that completes the access phase
        wr     = psel && penable && pwrite && s_r.pready && !s_r.pslverr;
        wmask  = {{8{pstrb[1]}}, {8{pstrb[0]}}};
        wd     = pwdata[15:0] & wmask;
        events = 8'h00;
        w1c    = 8'h00;

        for (int i = 0; i < 4; i++) begin
            single_vec[i] = s_r.chan[i].single;
            series_vec[i] = s_r.chan[i].series;
        end

        if (s_r.tick_cnt == TICK_W'(TICK_CYCLES_P - 1)) begin
            s_nxt.tick_cnt = '0;
            s_nxt.tick     = 1'b1;
        end else begin
            s_nxt.tick_cnt = s_r.tick_cnt + TICK_W'(1);
        end

        // address decode and read mux
        mapped = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
        rdata  = 32'h0000_0000;
        unique case (idx)
            IDX_ENABLE:     rdata = {28'h000_0000, s_r.enable};
            IDX_TRIGGER:    rdata = {16'h0000, single_vec, series_vec, 8'h00};
            IDX_INTERVAL:   rdata = {20'h0_0000, s_r.line_period, 4'h0, s_r.hp_period};
            IDX_COUNT_LINE: rdata = {25'h000_0000, s_r.line_count};
            IDX_COUNT_HP:   rdata = {25'h000_0000, s_r.hp_count};
            IDX_VALUE_LR:   rdata = {24'h00_0000, s_r.chan[3].value};
            IDX_VALUE_LL:   rdata = {24'h00_0000, s_r.chan[2].value};
            IDX_VALUE_HR:   rdata = {24'h00_0000, s_r.chan[1].value};
            IDX_VALUE_HL:   rdata = {24'h00_0000, s_r.chan[0].value};
            IDX_IRQ_STATUS: rdata = {24'h00_0000, s_r.irq_status};
            IDX_IRQ_MASK:   rdata = {24'h00_0000, s_r.irq_mask};
            default:        mapped = 1'b0;
        endcase

        // answer is ready one cycle after setup, so access lasts one cycle
        if (setup) begin
            s_nxt.pready  = 1'b1;
            s_nxt.pslverr = !mapped;
            s_nxt.prdata  = mapped ? rdata : 32'h0000_0000;
        end

        // register writes, byte lanes 0 and 1 only carry data
        old16       = rdata[15:0];
        new16       = (old16 & ~wmask) | wd;
        trig_single = 4'h0;
        trig_series = 4'h0;
        if (wr) begin
            unique case (idx)
                IDX_ENABLE:     s_nxt.enable = new16[3:0];
                IDX_TRIGGER: begin
                    // write one starts a one-shot correction
                    trig_single = wd[SINGLE_LSB +: 4];
                    trig_series = wd[SERIES_LSB +: 4];
                end
                IDX_INTERVAL: begin
                    s_nxt.line_period = new16[LINE_PERIOD_LSB +: 4];
                    s_nxt.hp_period   = new16[HP_PERIOD_LSB +: 4];
                    s_nxt.restart     = 1'b1;
                end
                IDX_COUNT_LINE: s_nxt.line_count = new16[6:0];
                IDX_COUNT_HP:   s_nxt.hp_count   = new16[6:0];
                IDX_IRQ_STATUS: w1c = wd[7:0];
                IDX_IRQ_MASK:   s_nxt.irq_mask = new16[7:0];
                default: begin
                end
            endcase
        end

        // timer pulses schedule a one-shot on both channels of the pair
        fire_vec = {line_fire, line_fire, hp_fire, hp_fire};

        for (int i = 0; i < 4; i++) begin
            // no servo activity on a disabled channel; a run in flight is dropped
            if (!s_r.enable[i]) begin
                s_nxt.chan[i].phase    = DOS_IDLE;
                s_nxt.chan[i].single   = 1'b0;
                s_nxt.chan[i].series   = 1'b0;
                s_nxt.chan[i].meas_cnt = '0;
            end else begin
                unique case (s_r.chan[i].phase)
                    DOS_IDLE: begin
                        if (s_r.chan[i].single || s_r.chan[i].series) begin
                            s_nxt.chan[i].phase    = DOS_MEAS;
                            s_nxt.chan[i].meas_cnt = '0;
                        end
                    end
                    DOS_MEAS: begin
                        if (s_r.chan[i].meas_cnt == MEAS_W'(MEAS_CYCLES - 1)) begin
                            s_nxt.chan[i].phase = DOS_IDLE;
                            // one step at most, saturating at the range ends
                            if (offset_high[i]) begin
                                if (s_r.chan[i].value != VALUE_MIN) begin
                                    s_nxt.chan[i].value = s_r.chan[i].value - 8'h01;
                                end
                            end else if (s_r.chan[i].value != VALUE_MAX) begin
                                s_nxt.chan[i].value = s_r.chan[i].value + 8'h01;
                            end
                            if (s_r.chan[i].single) begin
                                s_nxt.chan[i].single = 1'b0;
                                events[i]            = 1'b1;
                            end
                            // count+1 updates, flag drops after the last
                            if (s_r.chan[i].series) begin
                                if (s_r.chan[i].series_left == 7'h00) begin
                                    s_nxt.chan[i].series          = 1'b0;
                                    events[IRQ_SERIES_LSB + i]    = 1'b1;
                                end else begin
                                    s_nxt.chan[i].series_left =
                                        s_r.chan[i].series_left - 7'h01;
                                end
                            end
                        end else begin
                            s_nxt.chan[i].meas_cnt = s_r.chan[i].meas_cnt + MEAS_W'(1);
                        end
                    end
                endcase
                // requests after completion so a request in the finishing cycle survives
                if (trig_single[i] || fire_vec[i]) begin
                    s_nxt.chan[i].single = 1'b1;
                end
                // a retrigger during a run is absorbed by the run in flight
                if (trig_series[i] && !s_r.chan[i].series) begin
                    s_nxt.chan[i].series      = 1'b1;
                    s_nxt.chan[i].series_left = (i < 2) ? s_r.hp_count : s_r.line_count;
                end
            end
        end

        // sticky status: a new event wins over a same-cycle clear
        s_nxt.irq_status = (s_r.irq_status & ~w1c) | events;
        s_nxt.irq        = |(s_nxt.irq_status & s_nxt.irq_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= DOS_STATE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata  = s_r.prdata;
    assign pready  = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign irq     = s_r.irq;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            channel_offset_value[i] = s_r.chan[i].value;
        end
    end

endmodule : dos_servo
`default_nettype wire

// ---- verification/dos_servo_assertions.sv ----
// port-level concurrent checks for the dc offset servo block
`timescale 1ns/1ps
`default_nettype none
module dos_servo_checker
    import dos_pkg::*;
#(
    parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
    input wire logic            pclk,
    input wire logic            presetn,
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pwrite,
    input wire logic [11:0]     paddr,
    input wire logic [31:0]     prdata,
    input wire logic            pready,
    input wire logic            pslverr,
    input wire logic [3:0][7:0] channel_offset_value
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_only_once: assert property (!(psel && !penable) |=> !pready)
        else $error("ready without a setup cycle");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_error_with_ready: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error without ready or with data");
    a_trigger_low_zero: assert property (
        pready && !pwrite && paddr == 12'h110 |-> prdata[7:0] == 8'h00 && prdata[31:16] == 16'h0)
        else $error("trigger register spare bits set");
    for (genvar c = 0; c < 4; c++) begin : g_ch
        a_offset_one_step: assert property (
            ({channel_offset_value[c][7], channel_offset_value[c]}
             - {$past(channel_offset_value[c][7]), $past(channel_offset_value[c])})
            inside {9'h000, 9'h001, 9'h1ff})
            else $error("offset moved by more than one step");
        a_offset_settles: assert property (
            $changed(channel_offset_value[c]) |=> $stable(channel_offset_value[c]) [*8])
            else $error("offset changed without a full measurement");
    end
endmodule : dos_servo_checker

bind dos_servo dos_servo_checker #(.TICK_CYCLES_P(TICK_CYCLES_P)) dos_servo_checker_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .channel_offset_value(channel_offset_value));
`default_nettype wire

// ---- verification/tb_dos_servo.sv ----
// self-checking testbench for the dc offset servo block
`timescale 1ns/1ps
`default_nettype none
module tb_dos_servo
    import dos_pkg::*;
;
    // short tick of 20 cycles keeps periodic fires within a couple of hundred cycles
    localparam int unsigned TICKS = 20;
    localparam int unsigned LIMIT = 20000;
    logic                pclk        = 1'b0;
    logic                presetn     = 1'b0;
    logic                psel        = 1'b0;
    logic                penable     = 1'b0;
    logic                pwrite      = 1'b0;
    logic [11:0]         paddr       = 12'h000;
    logic [31:0]         pwdata      = 32'h0;
    logic [3:0]          offset_high = 4'h0;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic [3:0][7:0]     channel_offset_value;
    logic                irq;
    logic [31:0]         rdata_q;
    logic                err_q;
    logic [3:0][7:0]     ev;
    int                  num_errors  = 0;
    int                  samples_checked = 0;
    int                  cycles      = 0;

    dos_servo #(.TICK_CYCLES_P(TICKS)) dos_servo_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .offset_high(offset_high),
        .channel_offset_value(channel_offset_value), .irq(irq));

    always #20 pclk = ~pclk;

    function automatic logic [11:0] ad(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction : ad

    task automatic summarize();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // request held until the rising edge where ready is sampled high; answer taken at that edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata_q = prdata;
        err_q   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rdata_q);
    endtask : rdchk

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            apb(1'b0, ad(IDX_TRIGGER), 32'h0);
            n++;
        end while (rdata_q !== 32'h0 && n < 100);
        chk("trigger idle", 32'h0, rdata_q);
    endtask : wait_idle

    task automatic test_reset();
        rdchk("enable", ad(IDX_ENABLE), 32'h0);
        rdchk("trigger", ad(IDX_TRIGGER), 32'h0);
        rdchk("interval", ad(IDX_INTERVAL), 32'h0a0a);
        rdchk("count line", ad(IDX_COUNT_LINE), 32'h2a);
        rdchk("count hp", ad(IDX_COUNT_HP), 32'h2a);
        apb(1'b0, 12'h0fc, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err_q});
        apb(1'b1, 12'h111, 32'hffff);
        chk("misaligned err", 32'h1, {31'h0, err_q});
    endtask : test_reset

    task automatic test_disabled();
        apb(1'b1, ad(IDX_TRIGGER), 32'hff00);
        rdchk("trigger disabled", ad(IDX_TRIGGER), 32'h0);
        chk("offsets disabled", 32'h0, channel_offset_value);
    endtask : test_disabled

    task automatic test_single();
        offset_high <= 4'b0101;
        apb(1'b1, ad(IDX_ENABLE), 32'hf);
        apb(1'b1, ad(IDX_TRIGGER), 32'hf000);
        rdchk("single busy", ad(IDX_TRIGGER), 32'hf000);
        wait_idle();
        ev = {8'h01, 8'hff, 8'h01, 8'hff};
        chk("single offsets", ev, channel_offset_value);
        rdchk("value hl", ad(IDX_VALUE_HL), 32'hff);
        rdchk("value lr", ad(IDX_VALUE_LR), 32'h01);
        rdchk("status single", ad(IDX_IRQ_STATUS), 32'h0f);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, ad(IDX_IRQ_MASK), 32'h01);
        @(negedge pclk);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        apb(1'b1, ad(IDX_IRQ_STATUS), 32'h0f);
        @(negedge pclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rdchk("status cleared", ad(IDX_IRQ_STATUS), 32'h0);
    endtask : test_single

    task automatic test_series();
        offset_high <= 4'h0;
        apb(1'b1, ad(IDX_COUNT_HP), 32'h2);
        apb(1'b1, ad(IDX_COUNT_LINE), 32'h0);
        apb(1'b1, ad(IDX_TRIGGER), 32'h0500);
        rdchk("series busy", ad(IDX_TRIGGER), 32'h0500);
        wait_idle();
        ev[0] = 8'h02;
        ev[2] = 8'h00;
        chk("series offsets", ev, channel_offset_value);
        rdchk("status series", ad(IDX_IRQ_STATUS), 32'h50);
        apb(1'b1, ad(IDX_VALUE_HL), 32'h55);
        chk("value write err", 32'h0, {31'h0, err_q});
        chk("value read only", ev, channel_offset_value);
        // the read-back offset still equals the servo value after the ignored write
        rdchk("value reuse", ad(IDX_VALUE_HL), {24'h00_0000, ev[0]});
        apb(1'b1, ad(IDX_IRQ_STATUS), 32'hff);
    endtask : test_series

    task automatic test_periodic();
        // line fires after 4 ticks, headphone after 8, so only line lands first
        apb(1'b1, ad(IDX_INTERVAL), 32'h0203);
        repeat (40) @(posedge pclk);
        chk("periodic early", ev, channel_offset_value);
        repeat (70) @(posedge pclk);
        ev[2] = 8'h01;
        ev[3] = 8'h02;
        chk("periodic line", ev, channel_offset_value);
        apb(1'b1, ad(IDX_INTERVAL), 32'h0);
        repeat (200) @(posedge pclk);
        chk("periodic off", ev, channel_offset_value);
    endtask : test_periodic

    always @(posedge pclk) begin
        cycles++;
        if (cycles > LIMIT) begin
            num_errors++;
            summarize();
        end
    end

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
        test_disabled();
        test_single();
        test_series();
        test_periodic();
        summarize();
    end
endmodule : tb_dos_servo
`default_nettype wire
